// >>> src/ppc_pkg.sv
// shared constants for the port pin control block
`default_nettype none
package ppc_pkg;
  localparam int PPC_FIRST_W = 6;
  localparam int PPC_GRP_W = 8;
  localparam int PPC_BUSCTL_W = 3;
  // register byte offsets on the bus
  localparam logic [7:0] PPC_FIRST_LATCH_OFS = 8'h00;
  localparam logic [7:0] PPC_BUS_CTL_PORT_OFS = 8'h04;
  localparam logic [7:0] PPC_BUS_CTL_DIR_OFS = 8'h08;
  localparam logic [7:0] PPC_GRP2_PORT_OFS = 8'h0c;
  localparam logic [7:0] PPC_GRP2_DIR_OFS = 8'h10;
  localparam logic [7:0] PPC_GRP3_PORT_OFS = 8'h14;
  localparam logic [7:0] PPC_GRP3_DIR_OFS = 8'h18;
  localparam logic [7:0] PPC_GRP4_PORT_OFS = 8'h1c;
  localparam logic [7:0] PPC_GRP4_DIR_OFS = 8'h20;
  localparam logic [7:0] PPC_CTRL_OFS = 8'h24;
  // first group pin positions
  localparam int PPC_TMR_CLK_BIT = 1;
  localparam int PPC_OD_LO_BIT = 2;
  localparam int PPC_OD_HI_BIT = 3;
  localparam int PPC_SER_ONE_BIT = 4;
  localparam int PPC_SER_TWO_BIT = 5;
  // control register fields
  localparam int PPC_CTRL_MODE_LSB = 0;
  localparam int PPC_CTRL_PWM_BIT = 2;
  localparam int PPC_CTRL_SER_BIT = 3;
  // bus control pin positions
  localparam int PPC_ALE_BIT = 0;
  localparam int PPC_RD_N_BIT = 1;
  localparam int PPC_WR_N_BIT = 2;
  localparam logic [7:0] PPC_LATCH_RST = 8'h00;
  localparam logic [7:0] PPC_FIRST_RST = 8'h3f;
  localparam logic [7:0] PPC_DIR_RST = 8'hff;
  // plain microcontroller mode, peripherals off
  localparam logic [3:0] PPC_CTRL_RST = 4'h2;
  localparam logic [1:0] PPC_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] PPC_HSIZE_WORD = 3'h2;
  // processor modes: bus modes expose the external bus
  typedef enum logic [1:0] {
    PPC_MODE_MICROPROC = 2'h0,
    PPC_MODE_EXT_MCU = 2'h1,
    PPC_MODE_MCU = 2'h2,
    PPC_MODE_PROT_MCU = 2'h3
  } ppc_mode_t;
  function automatic logic ppc_is_bus_mode(input logic [1:0] m);
    ppc_is_bus_mode = (m == PPC_MODE_MICROPROC) || (m == PPC_MODE_EXT_MCU);
  endfunction
endpackage
`default_nettype wire

// >>> src/ppc_sync.sv
// two-flop synchroniser for a pin group
`timescale 1ns/1ps
`default_nettype none
module ppc_sync #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_reg <= '0;
      q_reg <= '0;
    end
    else
    begin
      meta_reg <= d;
      q_reg <= meta_reg;
    end
  end
  assign q = q_reg;
endmodule
`default_nettype wire

// >>> src/ppc_port_pin_control.sv
// port pin control: five pin groups with AHB-Lite register access
// Operation
// - Five pin groups total 33 pins and every group but the first has a direction register.
// - Groups three to five carry the external bus in bus modes and are plain I/O otherwise.
// - Turning on the PWM or serial unit hands its pins over without touching direction bits.
// - A direction bit under a forcing peripheral is kept as it was and software rewrites it afterwards.
// - A peripheral input still sees its pin when that pin is driven as an output.
// - The first group is a 6-bit latch without direction and reads return the pin levels.
// - The timer clock pin feeds the timer input and the serial unit takes the two serial pins.
// - The two open-drain pins drive low on a latch zero and float on a latch one.
// - A write to the first group changes only the open-drain outputs.
// - The bus control group is 3 bits wide and a direction one means input, zero output.
// - Reading the bus control group returns pins and writing only updates its latch.
// - In bus mode the bus control group carries address latch, low read and low write strobes.
`timescale 1ns/1ps
`default_nettype none
module ppc_port_pin_control
  import ppc_pkg::*;
#(
  parameter int GRP_W = PPC_GRP_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [PPC_FIRST_W-1:0] first_pin_in,
  output logic [PPC_FIRST_W-1:0] first_pin_out,
  output logic [PPC_FIRST_W-1:0] first_pin_oe_n,
  input wire logic [GRP_W-1:0] second_pin_in,
  output logic [GRP_W-1:0] second_pin_out,
  output logic [GRP_W-1:0] second_pin_oe_n,
  input wire logic [GRP_W-1:0] third_pin_in,
  output logic [GRP_W-1:0] third_pin_out,
  output logic [GRP_W-1:0] third_pin_oe_n,
  input wire logic [GRP_W-1:0] fourth_pin_in,
  output logic [GRP_W-1:0] fourth_pin_out,
  output logic [GRP_W-1:0] fourth_pin_oe_n,
  input wire logic [PPC_BUSCTL_W-1:0] bus_control_pin_in,
  output logic [PPC_BUSCTL_W-1:0] bus_control_pin_out,
  output logic [PPC_BUSCTL_W-1:0] bus_control_pin_oe_n,
  input wire logic ext_ale,
  input wire logic ext_rd_n,
  input wire logic ext_wr_n,
  input wire logic [GRP_W-1:0] ext_ad_lo_out,
  input wire logic [GRP_W-1:0] ext_ad_hi_out,
  input wire logic ext_ad_oe_n,
  output logic [GRP_W-1:0] ext_ad_lo_in,
  output logic [GRP_W-1:0] ext_ad_hi_in,
  input wire logic pwm_out,
  input wire logic ser_tx_out,
  input wire logic ser_tx_oe_n,
  input wire logic ser_aux_out,
  input wire logic ser_aux_oe_n,
  output logic ser_rx_in,
  output logic timer_zero_clk,
  output logic [GRP_W-1:0] second_pin_levels,
  output logic bus_mode
);
  localparam int PWM_PIN = GRP_W - 1;

  logic [PPC_FIRST_W-1:0] first_sync;
  logic [GRP_W-1:0] second_sync;
  logic [GRP_W-1:0] third_sync;
  logic [GRP_W-1:0] fourth_sync;
  logic [PPC_BUSCTL_W-1:0] busctl_sync;

  // all pin inputs cross two flops before anything reads them
  ppc_sync #(.W(PPC_FIRST_W + 3 * GRP_W + PPC_BUSCTL_W)) u_sync (
    .clk(clk),
    .rst(rst),
    .d({first_pin_in, second_pin_in, third_pin_in, fourth_pin_in, bus_control_pin_in}),
    .q({first_sync, second_sync, third_sync, fourth_sync, busctl_sync})
  );

  logic [PPC_FIRST_W-1:0] first_latch_reg, first_latch_next;
  logic [GRP_W-1:0] lat2_reg, lat2_next, dir2_reg, dir2_next;
  logic [GRP_W-1:0] lat3_reg, lat3_next, dir3_reg, dir3_next;
  logic [GRP_W-1:0] lat4_reg, lat4_next, dir4_reg, dir4_next;
  logic [PPC_BUSCTL_W-1:0] bus_control_port_reg, bus_control_port_next;
  logic [PPC_BUSCTL_W-1:0] bus_control_direction_reg, bus_control_direction_next;
  logic [3:0] ctrl_reg, ctrl_next;
  logic wr_pend_reg, wr_pend_next;
  logic [7:0] wr_addr_reg, wr_addr_next;
  logic [31:0] hrdata_reg, hrdata_next;

  logic addr_ok;
  logic pwm_on;
  logic ser_on;
  assign addr_ok = hsel && hready && (htrans == PPC_HTRANS_NONSEQ) && (hsize == PPC_HSIZE_WORD);
  assign pwm_on = ctrl_reg[PPC_CTRL_PWM_BIT];
  assign ser_on = ctrl_reg[PPC_CTRL_SER_BIT];

  assign bus_mode = ppc_is_bus_mode(ctrl_reg[PPC_CTRL_MODE_LSB +: 2]);

  function automatic logic [31:0] zext8(input logic [GRP_W-1:0] v);
    zext8 = 32'(v);
  endfunction

  // register writes land in the data phase; port reads answer from pins with zero wait
  always_comb
  begin
    first_latch_next = first_latch_reg;
    lat2_next = lat2_reg;
    dir2_next = dir2_reg;
    lat3_next = lat3_reg;
    dir3_next = dir3_reg;
    lat4_next = lat4_reg;
    dir4_next = dir4_reg;
    bus_control_port_next = bus_control_port_reg;
    bus_control_direction_next = bus_control_direction_reg;
    ctrl_next = ctrl_reg;
    wr_pend_next = addr_ok && hwrite;
    wr_addr_next = addr_ok ? haddr[7:0] : wr_addr_reg;
    hrdata_next = hrdata_reg;
    if (wr_pend_reg)
    begin
      case (wr_addr_reg)
        // only the open-drain bits have effect on pins
        PPC_FIRST_LATCH_OFS: first_latch_next = hwdata[PPC_FIRST_W-1:0];
        PPC_GRP2_PORT_OFS: lat2_next = hwdata[GRP_W-1:0];
        PPC_GRP2_DIR_OFS: dir2_next = hwdata[GRP_W-1:0];
        PPC_GRP3_PORT_OFS: lat3_next = hwdata[GRP_W-1:0];
        PPC_GRP3_DIR_OFS: dir3_next = hwdata[GRP_W-1:0];
        PPC_GRP4_PORT_OFS: lat4_next = hwdata[GRP_W-1:0];
        PPC_GRP4_DIR_OFS: dir4_next = hwdata[GRP_W-1:0];
        // write goes to the latch only
        PPC_BUS_CTL_PORT_OFS: bus_control_port_next = hwdata[PPC_BUSCTL_W-1:0];
        // upper direction bits are not stored
        PPC_BUS_CTL_DIR_OFS: bus_control_direction_next = hwdata[PPC_BUSCTL_W-1:0];
        PPC_CTRL_OFS: ctrl_next = hwdata[3:0];
        default: ;
      endcase
    end
    // a forced pin's direction bit is left as it was; software rewrites it
    if (addr_ok && !hwrite)
    begin
      case (haddr[7:0])
        PPC_FIRST_LATCH_OFS: hrdata_next = 32'(first_sync);
        PPC_GRP2_PORT_OFS: hrdata_next = zext8(second_sync);
        PPC_GRP2_DIR_OFS: hrdata_next = zext8(dir2_reg);
        PPC_GRP3_PORT_OFS: hrdata_next = zext8(third_sync);
        PPC_GRP3_DIR_OFS: hrdata_next = zext8(dir3_reg);
        PPC_GRP4_PORT_OFS: hrdata_next = zext8(fourth_sync);
        PPC_GRP4_DIR_OFS: hrdata_next = zext8(dir4_reg);
        PPC_BUS_CTL_PORT_OFS: hrdata_next = 32'(busctl_sync);
        PPC_BUS_CTL_DIR_OFS: hrdata_next = 32'(bus_control_direction_reg);
        PPC_CTRL_OFS: hrdata_next = 32'(ctrl_reg);
        default: hrdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      first_latch_reg <= PPC_FIRST_RST[PPC_FIRST_W-1:0];
      lat2_reg <= PPC_LATCH_RST[GRP_W-1:0];
      dir2_reg <= PPC_DIR_RST[GRP_W-1:0];
      lat3_reg <= PPC_LATCH_RST[GRP_W-1:0];
      dir3_reg <= PPC_DIR_RST[GRP_W-1:0];
      lat4_reg <= PPC_LATCH_RST[GRP_W-1:0];
      dir4_reg <= PPC_DIR_RST[GRP_W-1:0];
      bus_control_port_reg <= PPC_LATCH_RST[PPC_BUSCTL_W-1:0];
      bus_control_direction_reg <= PPC_DIR_RST[PPC_BUSCTL_W-1:0];
      ctrl_reg <= PPC_CTRL_RST;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata_reg <= 32'h0000_0000;
    end
    else
    begin
      first_latch_reg <= first_latch_next;
      lat2_reg <= lat2_next;
      dir2_reg <= dir2_next;
      lat3_reg <= lat3_next;
      dir3_reg <= dir3_next;
      lat4_reg <= lat4_next;
      dir4_reg <= dir4_next;
      bus_control_port_reg <= bus_control_port_next;
      bus_control_direction_reg <= bus_control_direction_next;
      ctrl_reg <= ctrl_next;
      wr_pend_reg <= wr_pend_next;
      wr_addr_reg <= wr_addr_next;
      hrdata_reg <= hrdata_next;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;

  // pin drive, combinational from registers and peripheral outputs
  always_comb
  begin
    // open drain: drive low on zero, float on one
    first_pin_out = '0;
    first_pin_oe_n = '1;
    first_pin_oe_n[PPC_OD_LO_BIT] = first_latch_reg[PPC_OD_LO_BIT];
    first_pin_oe_n[PPC_OD_HI_BIT] = first_latch_reg[PPC_OD_HI_BIT];
    // serial unit owns its two pins
    if (ser_on)
    begin
      first_pin_out[PPC_SER_TWO_BIT] = ser_tx_out;
      first_pin_oe_n[PPC_SER_TWO_BIT] = ser_tx_oe_n;
      first_pin_out[PPC_SER_ONE_BIT] = ser_aux_out;
      first_pin_oe_n[PPC_SER_ONE_BIT] = ser_aux_oe_n;
    end
    // direction one means input on every group with a direction register
    second_pin_out = lat2_reg;
    second_pin_oe_n = dir2_reg;
    // pwm takes its pin regardless of direction bit
    if (pwm_on)
    begin
      second_pin_out[PWM_PIN] = pwm_out;
      second_pin_oe_n[PWM_PIN] = 1'b0;
    end
    // bus modes hand groups three to five to the external bus
    if (bus_mode)
    begin
      third_pin_out = ext_ad_lo_out;
      third_pin_oe_n = {GRP_W{ext_ad_oe_n}};
      fourth_pin_out = ext_ad_hi_out;
      fourth_pin_oe_n = {GRP_W{ext_ad_oe_n}};
      // strobe mapping, read and write strobes active low
      bus_control_pin_out = '0;
      bus_control_pin_out[PPC_ALE_BIT] = ext_ale;
      bus_control_pin_out[PPC_RD_N_BIT] = ext_rd_n;
      bus_control_pin_out[PPC_WR_N_BIT] = ext_wr_n;
      bus_control_pin_oe_n = '0;
    end
    else
    begin
      third_pin_out = lat3_reg;
      third_pin_oe_n = dir3_reg;
      fourth_pin_out = lat4_reg;
      fourth_pin_oe_n = dir4_reg;
      // direction one is input, zero is output
      bus_control_pin_out = bus_control_port_reg;
      bus_control_pin_oe_n = bus_control_direction_reg;
    end
  end

  // peripherals see synchronised pin levels, even of driven pins
  assign second_pin_levels = second_sync;
  // timer clock input from its pin
  assign timer_zero_clk = first_sync[PPC_TMR_CLK_BIT];
  assign ser_rx_in = first_sync[PPC_SER_TWO_BIT];
  assign ext_ad_lo_in = third_sync;
  assign ext_ad_hi_in = fourth_sync;

  od_never_high_a: assert property (@(posedge clk) disable iff (rst)
    first_pin_oe_n[PPC_OD_LO_BIT] == first_latch_reg[PPC_OD_LO_BIT]
      && !(!first_pin_oe_n[PPC_OD_LO_BIT] && first_pin_out[PPC_OD_LO_BIT])
      && !(!first_pin_oe_n[PPC_OD_HI_BIT] && first_pin_out[PPC_OD_HI_BIT]))
    else $error("open drain low pin enable wrong");
  // write to first group reaches open drain pin two cycles after its address phase
  od_write_a: assert property (@(posedge clk) disable iff (rst)
    (addr_ok && hwrite && haddr[7:0] == PPC_FIRST_LATCH_OFS) ##1 1'b1
      |=> first_pin_oe_n[PPC_OD_HI_BIT] == $past(hwdata[PPC_OD_HI_BIT]))
    else $error("open drain write did not reach pin");
  dir_upper_a: assert property (@(posedge clk) disable iff (rst)
    (addr_ok && !hwrite && haddr[7:0] == PPC_BUS_CTL_DIR_OFS)
      |=> hrdata[31:PPC_BUSCTL_W] == '0)
    else $error("direction upper bits not zero");
  // read strobe follows the bus and all bus control pins drive in bus mode
  strobe_map_a: assert property (@(posedge clk) disable iff (rst)
    bus_mode |-> bus_control_pin_out[PPC_RD_N_BIT] == ext_rd_n && bus_control_pin_oe_n == '0)
    else $error("bus strobe mapping wrong");
  // direction steers the pin in port mode
  dir_steer_a: assert property (@(posedge clk) disable iff (rst)
    !bus_mode |-> bus_control_pin_oe_n == bus_control_direction_reg)
    else $error("bus control direction not applied");
  // read returns pins three cycles after they settle
  first_read_a: assert property (@(posedge clk) disable iff (rst)
    (addr_ok && !hwrite && haddr[7:0] == PPC_FIRST_LATCH_OFS)
      |=> hrdata[PPC_FIRST_W-1:0] == $past(first_sync))
    else $error("first group read not from pins");
  // pwm pin always driven while pwm on
  pwm_take_a: assert property (@(posedge clk) disable iff (rst)
    pwm_on |-> !second_pin_oe_n[PWM_PIN] && second_pin_out[PWM_PIN] == pwm_out)
    else $error("pwm pin not taken");
  // peripheral sees driven level after two flops
  periph_sees_a: assert property (@(posedge clk) disable iff (rst)
    (!$past(rst) && !$past(rst, 2)) |-> second_pin_levels == $past(second_pin_in, 2))
    else $error("peripheral input not from pin");
endmodule
`default_nettype wire

// >>> verification/ppc_pin_model.sv
// pad model: resolves each pin from the port drive and the outside world
`timescale 1ns/1ps
`default_nettype none
module ppc_pin_model #(
  parameter int W = 8,
  parameter logic [W-1:0] PULL_UP = '0
) (
  input wire logic [W-1:0] pin_out,
  input wire logic [W-1:0] pin_oe_n,
  input wire logic [W-1:0] ext_drive,
  output logic [W-1:0] pin_level
);
  // a released open-drain pin only ever sees its pull-up
  always_comb
  begin
    for (int i = 0; i < W; i++)
    begin
      if (pin_oe_n[i] == 1'b0)
        pin_level[i] = pin_out[i];
      else if (PULL_UP[i])
        pin_level[i] = 1'b1;
      else
        pin_level[i] = ext_drive[i];
    end
  end
endmodule
`default_nettype wire

// >>> verification/port_pin_control_tb.sv
// self-checking bench for the port pin control block
`timescale 1ns/1ps
`default_nettype none
module port_pin_control_tb;
  import ppc_pkg::*;
  logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h0, b_in, b_out, b_oe_n, b_ext = 3'h2;
  logic [5:0] f_in, f_out, f_oe_n, f_ext = 6'h21;
  logic [7:0] s_in, s_out, s_oe_n, s_lvl, s_ext = 8'h3c, t_ext = 8'h96, u_ext = 8'h69;
  logic [7:0] t_out, t_oe_n, ad_lo_o = 8'h5a, ad_hi_o = 8'hc3, ad_lo_i;
  logic [7:0] u_out, u_oe_n, ad_hi_i;
  logic ale = 1'b0, rdn = 1'b1, wrn = 1'b1, ad_oe_n = 1'b1, pwm = 1'b0;
  logic tx = 1'b0, tx_oe_n = 1'b1, aux = 1'b0, aux_oe_n = 1'b1, rx, t0clk, bmode;
  int err_total = 0;
  int comparisons = 0;

  always #2 clk = ~clk;

  ppc_pin_model #(.W(6), .PULL_UP(6'h0c)) first_pads (.pin_out(f_out), .pin_oe_n(f_oe_n),
    .ext_drive(f_ext), .pin_level(f_in));
  ppc_pin_model #(.W(8)) second_pads (.pin_out(s_out), .pin_oe_n(s_oe_n),
    .ext_drive(s_ext), .pin_level(s_in));
  ppc_pin_model #(.W(3)) ctl_pads (.pin_out(b_out), .pin_oe_n(b_oe_n),
    .ext_drive(b_ext), .pin_level(b_in));

  ppc_port_pin_control dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .first_pin_in(f_in),
    .first_pin_out(f_out), .first_pin_oe_n(f_oe_n), .second_pin_in(s_in),
    .second_pin_out(s_out), .second_pin_oe_n(s_oe_n), .third_pin_in(t_ext),
    .third_pin_out(t_out), .third_pin_oe_n(t_oe_n), .fourth_pin_in(u_ext),
    .fourth_pin_out(u_out), .fourth_pin_oe_n(u_oe_n), .bus_control_pin_in(b_in),
    .bus_control_pin_out(b_out), .bus_control_pin_oe_n(b_oe_n), .ext_ale(ale),
    .ext_rd_n(rdn), .ext_wr_n(wrn), .ext_ad_lo_out(ad_lo_o), .ext_ad_hi_out(ad_hi_o),
    .ext_ad_oe_n(ad_oe_n), .ext_ad_lo_in(ad_lo_i), .ext_ad_hi_in(ad_hi_i), .pwm_out(pwm),
    .ser_tx_out(tx), .ser_tx_oe_n(tx_oe_n), .ser_aux_out(aux), .ser_aux_oe_n(aux_oe_n),
    .ser_rx_in(rx), .timer_zero_clk(t0clk), .second_pin_levels(s_lvl), .bus_mode(bmode));

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // bounded wait for hready at a rising edge
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1)
    begin
      n++;
      if (n > 50)
      begin
        err_total++;
        summarize();
      end
      @(posedge clk);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [2:0] sz, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= sz;
    htrans <= PPC_HTRANS_NONSEQ;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, PPC_HSIZE_WORD, rd);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0, PPC_HSIZE_WORD, rd);
    chk(rd, e);
  endtask

  // pins are synchronised, so give outputs and reads time to settle
  task automatic settle;
    repeat (4) @(posedge clk);
  endtask

  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    // synchronisers need two edges out of reset before pin reads are valid
    settle();
    rd_chk(PPC_FIRST_LATCH_OFS, 32'h2d);
    rd_chk(PPC_BUS_CTL_DIR_OFS, 32'h07);
    rd_chk(8'h40, 32'h0);
    wr(PPC_FIRST_LATCH_OFS, 32'h08);
    settle();
    chk(f_oe_n, 6'h3b);
    chk(f_out[3:2], 2'h0);
    rd_chk(PPC_FIRST_LATCH_OFS, 32'h29);
    // byte-sized write must be dropped
    xfer(1'b1, PPC_FIRST_LATCH_OFS, 32'h0, 3'h0, rd);
    settle();
    chk(f_oe_n, 6'h3b);
    chk(hresp, 1'b0);
    // bank choice is software's; each register has its own word here
    wr(PPC_BUS_CTL_PORT_OFS, 32'h4);
    wr(PPC_BUS_CTL_DIR_OFS, 32'hfa);
    settle();
    chk(b_oe_n, 3'h2);
    chk({b_out[2], b_out[0]}, 2'h2);
    rd_chk(PPC_BUS_CTL_DIR_OFS, 32'h02);
    rd_chk(PPC_BUS_CTL_PORT_OFS, 32'h6);
    for (int m = 0; m < 4; m++)
    begin
      wr(PPC_CTRL_OFS, 32'(m));
      settle();
      chk(bmode, m < 2);
    end
    ale <= 1'b1;
    rdn <= 1'b0;
    ad_oe_n <= 1'b0;
    wr(PPC_CTRL_OFS, 32'h1);
    settle();
    chk(b_out, 3'h5);
    chk(b_oe_n, 3'h0);
    chk(t_out, ad_lo_o);
    chk(t_oe_n, 8'h00);
    chk(ad_lo_i, t_ext);
    chk(u_out, ad_hi_o);
    chk(u_oe_n, 8'h00);
    chk(ad_hi_i, u_ext);
    rdn <= 1'b1;
    wrn <= 1'b0;
    settle();
    chk(b_out, 3'h3);
    pwm <= 1'b1;
    tx_oe_n <= 1'b0;
    aux <= 1'b1;
    aux_oe_n <= 1'b0;
    wr(PPC_CTRL_OFS, 32'h0e);
    settle();
    chk({s_oe_n[7], s_out[7]}, 2'h1);
    chk({f_oe_n[5:4], f_out[5:4]}, 4'h1);
    wr(PPC_CTRL_OFS, 32'h2);
    rd_chk(PPC_GRP2_DIR_OFS, 32'hff);
    wr(PPC_GRP2_DIR_OFS, 32'hff);
    wr(PPC_GRP2_PORT_OFS, 32'ha5);
    wr(PPC_GRP2_DIR_OFS, 32'h00);
    settle();
    chk(s_lvl, 8'ha5);
    f_ext <= 6'h23;
    settle();
    chk({t0clk, rx}, 2'h3);
    f_ext <= 6'h01;
    settle();
    chk({t0clk, rx}, 2'h0);
    // groups three and four as plain I/O outside the bus modes
    wr(PPC_GRP3_PORT_OFS, 32'h3c);
    wr(PPC_GRP3_DIR_OFS, 32'h0f);
    wr(PPC_GRP4_PORT_OFS, 32'hc3);
    wr(PPC_GRP4_DIR_OFS, 32'hf0);
    settle();
    chk(t_out, 8'h3c);
    chk(t_oe_n, 8'h0f);
    chk(u_out, 8'hc3);
    chk(u_oe_n, 8'hf0);
    rd_chk(PPC_GRP3_DIR_OFS, 32'h0f);
    rd_chk(PPC_GRP4_DIR_OFS, 32'hf0);
    rd_chk(PPC_GRP3_PORT_OFS, 32'h96);
    rd_chk(PPC_GRP4_PORT_OFS, 32'h69);
    rd_chk(PPC_GRP2_PORT_OFS, 32'ha5);
    rd_chk(PPC_CTRL_OFS, 32'h2);
    // mid-run reset brings every register back
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    settle();
    chk(f_oe_n, 6'h3f);
    chk(s_oe_n, 8'hff);
    chk(bmode, 1'b0);
    rd_chk(PPC_BUS_CTL_DIR_OFS, 32'h07);
    rd_chk(PPC_FIRST_LATCH_OFS, 32'h0d);
    summarize();
  end
endmodule
`default_nettype wire
